//--- hw/gate4_pkg.sv
// Package with the register map, field positions and carriers of the cell.
package gate4_pkg;
    localparam int         DATA_W          = 32;
    localparam int         ADDR_W          = 8;
    localparam int         SEL_W           = 8;
    localparam logic [7:0] GATE4_SEL_OFF   = 8'h00;
    localparam logic [7:0] MIRROR_OFF      = 8'h04;
    localparam int         SEL_IN4_TRUE    = 7;
    localparam int         SEL_IN4_INV     = 6;
    localparam int         SEL_IN3_TRUE    = 5;
    localparam int         SEL_IN3_INV     = 4;
    localparam int         SEL_IN2_TRUE    = 3;
    localparam int         SEL_IN2_INV     = 2;
    localparam int         SEL_IN1_TRUE    = 1;
    localparam int         SEL_IN1_INV     = 0;
    localparam int         MIRROR_CELL2    = 1;
    localparam int         MIRROR_CELL1    = 0;
    localparam logic [1:0] MIRROR_RESET    = 2'h0;
    localparam logic       GATE_IDLE_LEVEL = 1'h0;

    // True forms of the four data inputs of one cell.
    typedef struct packed {
        logic data_in4_true;
        logic data_in3_true;
        logic data_in2_true;
        logic data_in1_true;
    } data_in_t;

    // Outputs of the two cells that are mirrored for software.
    typedef struct packed {
        logic cell2_output;
        logic cell1_output;
    } cell_out_t;
endpackage : gate4_pkg

//--- hw/sel_store.sv
// Selection storage flops that keep their contents across every reset.
`timescale 1ns/1ps
module sel_store #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    output logic      [WIDTH-1:0] data_q
);
    // No reset on purpose: the value is unknown at power-up and then
    // survives any later reset of the bus side.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            data_q <= wr_data;
        end
    end
endmodule : sel_store

//--- hw/logic_cell_gate4_select.sv
// Gate 4 input selection and cell output mirror behind an APB slave.
//
// Operation
// - Bit 7 gates true input 4.
// - Bit 6 gates inverted input 4.
// - Bit 5 gates true input 3.
// - Bit 4 gates inverted input 3.
// - Bit 3 gates true input 2.
// - Bit 2 gates inverted input 2.
// - Bit 1 gates true input 1.
// - Bit 0 gates inverted input 1.
// - Select bits read/write, unknown at power-up, kept.
// - Mirror bits copy cell outputs, reset zero.
// - Mirror bits 7..2 read zero, writes ignored.
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
module logic_cell_gate4_select #(
    parameter int ADDR_W = gate4_pkg::ADDR_W
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [ADDR_W-1:0]           paddr,
    input  wire logic [gate4_pkg::DATA_W-1:0] pwdata,
    output logic      [gate4_pkg::DATA_W-1:0] prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire gate4_pkg::data_in_t         data_in,
    input  wire gate4_pkg::cell_out_t        cell_out,
    output logic                             gate_four_signal
);
    logic [gate4_pkg::SEL_W-1:0] gate4_input_select;
    logic [1:0]                  mirror_q;
    logic                        setup;
    logic                        access;
    logic                        hit_sel;
    logic                        hit_mirror;
    logic                        sel_wr;

    // Forms a gate output from a select byte and the four true inputs.
    function automatic logic gate_or(
        input logic [7:0]          sel,
        input gate4_pkg::data_in_t d
    );
        logic [7:0] forms;
        forms = {d.data_in4_true, ~d.data_in4_true,
                 d.data_in3_true, ~d.data_in3_true,
                 d.data_in2_true, ~d.data_in2_true,
                 d.data_in1_true, ~d.data_in1_true};
        return |(sel & forms);
    endfunction : gate_or

    // Matches a bus address against a register offset.
    function automatic logic addr_is(
        input logic [ADDR_W-1:0] a,
        input logic [7:0]        off
    );
        return a == ADDR_W'(off);
    endfunction : addr_is

    // One-hot select pattern used by the exclusion checks.
    function automatic logic [7:0] only_bit(input int pos);
        return 8'h01 << pos;
    endfunction : only_bit

    assign setup      = psel && !penable;
    assign access     = psel && penable && pready;
    assign hit_sel    = addr_is(paddr, gate4_pkg::GATE4_SEL_OFF);
    assign hit_mirror = addr_is(paddr, gate4_pkg::MIRROR_OFF);
    assign sel_wr     = access && pwrite && hit_sel;

    sel_store #(
        .WIDTH (gate4_pkg::SEL_W)
    ) u_sel_store (
        .clk     (pclk),
        .wr_en   (sel_wr),
        .wr_data (pwdata[gate4_pkg::SEL_W-1:0]),
        .data_q  (gate4_input_select)
    );

    // Every transfer answers in its first access cycle, so pready is a
    // one-cycle pulse raised by the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    // Read data and error are registered in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= '0;
            pslverr <= !(hit_sel || hit_mirror);
            if (!pwrite && hit_sel) begin
                prdata[gate4_pkg::SEL_W-1:0] <= gate4_input_select;
            end else if (!pwrite && hit_mirror) begin
                prdata[1:0] <= mirror_q;
            end
        end else begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end
    end

    // The mirror has no write path; a write to it is simply dropped.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mirror_q <= gate4_pkg::MIRROR_RESET;
        end else begin
            mirror_q[gate4_pkg::MIRROR_CELL2] <= cell_out.cell2_output;
            mirror_q[gate4_pkg::MIRROR_CELL1] <= cell_out.cell1_output;
        end
    end

    // The gate is registered so the downstream stages see a glitch-free
    // level; the cost is one cycle of latency.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_four_signal <= gate4_pkg::GATE_IDLE_LEVEL;
        end else begin
            gate_four_signal <= gate_or(gate4_input_select, data_in);
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_IN4_TRUE: assert property (
        gate4_input_select[gate4_pkg::SEL_IN4_TRUE] && data_in.data_in4_true
        |=> gate_four_signal)
        else $error("Selected true input 4 did not raise gate 4.");

    AST_IN4_INV: assert property (
        gate4_input_select[gate4_pkg::SEL_IN4_INV] && !data_in.data_in4_true
        |=> gate_four_signal)
        else $error("Selected inverted input 4 did not raise gate 4.");

    AST_IN3_TRUE: assert property (
        gate4_input_select[gate4_pkg::SEL_IN3_TRUE] && data_in.data_in3_true
        |=> gate_four_signal)
        else $error("Selected true input 3 did not raise gate 4.");

    AST_IN3_INV: assert property (
        gate4_input_select[gate4_pkg::SEL_IN3_INV] && !data_in.data_in3_true
        |=> gate_four_signal)
        else $error("Selected inverted input 3 did not raise gate 4.");

    AST_IN2_TRUE: assert property (
        gate4_input_select[gate4_pkg::SEL_IN2_TRUE] && data_in.data_in2_true
        |=> gate_four_signal)
        else $error("Selected true input 2 did not raise gate 4.");

    AST_IN2_INV: assert property (
        gate4_input_select[gate4_pkg::SEL_IN2_INV] && !data_in.data_in2_true
        |=> gate_four_signal)
        else $error("Selected inverted input 2 did not raise gate 4.");

    AST_IN1_TRUE: assert property (
        gate4_input_select[gate4_pkg::SEL_IN1_TRUE] && data_in.data_in1_true
        |=> gate_four_signal)
        else $error("Selected true input 1 did not raise gate 4.");

    AST_IN1_INV: assert property (
        gate4_input_select[gate4_pkg::SEL_IN1_INV] && !data_in.data_in1_true
        |=> gate_four_signal)
        else $error("Selected inverted input 1 did not raise gate 4.");

    AST_GATE_IDLE: assert property (
        gate4_input_select == '0 |=> !gate_four_signal)
        else $error("Gate 4 left idle level with nothing selected.");

    sequence sel_write_s;
        psel && !penable && pwrite && hit_sel ##1 access;
    endsequence

    AST_SEL_WRITE: assert property (
        sel_write_s |=> gate4_input_select == $past(pwdata[7:0]))
        else $error("Select register did not take written byte.");

    AST_SEL_READ: assert property (
        setup && !pwrite && hit_sel
        |=> pready && prdata == {24'h000000, $past(gate4_input_select)})
        else $error("Select register read back wrong value.");

    AST_MIRROR_READ: assert property (
        setup && !pwrite && hit_mirror
        |=> pready && prdata == {30'h0, $past(mirror_q)})
        else $error("Mirror read wrong or upper bits not zero.");

    AST_MIRROR_TRACK: assert property (
        ##1 mirror_q == $past({cell_out.cell2_output, cell_out.cell1_output}))
        else $error("Mirror bits do not follow cell outputs.");

    // With one form selected and that form low, the opposite form of the
    // same input must not leak through to the gate.
    AST_IN4_TRUE_ONLY: assert property (
        gate4_input_select == only_bit(gate4_pkg::SEL_IN4_TRUE)
        && !data_in.data_in4_true |=> !gate_four_signal)
        else $error("Gate 4 high with only true input 4 selected.");

    AST_IN4_INV_ONLY: assert property (
        gate4_input_select == only_bit(gate4_pkg::SEL_IN4_INV)
        && data_in.data_in4_true |=> !gate_four_signal)
        else $error("Gate 4 high with only inverted input 4 selected.");

    AST_IN3_TRUE_ONLY: assert property (
        gate4_input_select == only_bit(gate4_pkg::SEL_IN3_TRUE)
        && !data_in.data_in3_true |=> !gate_four_signal)
        else $error("Gate 4 high with only true input 3 selected.");

    AST_IN3_INV_ONLY: assert property (
        gate4_input_select == only_bit(gate4_pkg::SEL_IN3_INV)
        && data_in.data_in3_true |=> !gate_four_signal)
        else $error("Gate 4 high with only inverted input 3 selected.");

    AST_IN2_TRUE_ONLY: assert property (
        gate4_input_select == only_bit(gate4_pkg::SEL_IN2_TRUE)
        && !data_in.data_in2_true |=> !gate_four_signal)
        else $error("Gate 4 high with only true input 2 selected.");

    AST_IN2_INV_ONLY: assert property (
        gate4_input_select == only_bit(gate4_pkg::SEL_IN2_INV)
        && data_in.data_in2_true |=> !gate_four_signal)
        else $error("Gate 4 high with only inverted input 2 selected.");

    AST_IN1_TRUE_ONLY: assert property (
        gate4_input_select == only_bit(gate4_pkg::SEL_IN1_TRUE)
        && !data_in.data_in1_true |=> !gate_four_signal)
        else $error("Gate 4 high with only true input 1 selected.");

    AST_IN1_INV_ONLY: assert property (
        gate4_input_select == only_bit(gate4_pkg::SEL_IN1_INV)
        && data_in.data_in1_true |=> !gate_four_signal)
        else $error("Gate 4 high with only inverted input 1 selected.");

    AST_IN4_BOTH: assert property (
        gate4_input_select[gate4_pkg::SEL_IN4_TRUE]
        && gate4_input_select[gate4_pkg::SEL_IN4_INV] |=> gate_four_signal)
        else $error("Both forms of input 4 selected, gate 4 stayed low.");

    AST_IN3_BOTH: assert property (
        gate4_input_select[gate4_pkg::SEL_IN3_TRUE]
        && gate4_input_select[gate4_pkg::SEL_IN3_INV] |=> gate_four_signal)
        else $error("Both forms of input 3 selected, gate 4 stayed low.");

    AST_IN2_BOTH: assert property (
        gate4_input_select[gate4_pkg::SEL_IN2_TRUE]
        && gate4_input_select[gate4_pkg::SEL_IN2_INV] |=> gate_four_signal)
        else $error("Both forms of input 2 selected, gate 4 stayed low.");

    AST_IN1_BOTH: assert property (
        gate4_input_select[gate4_pkg::SEL_IN1_TRUE]
        && gate4_input_select[gate4_pkg::SEL_IN1_INV] |=> gate_four_signal)
        else $error("Both forms of input 1 selected, gate 4 stayed low.");

    sequence bus_setup_s;
        psel && !penable;
    endsequence

    sequence bus_unmapped_s;
        psel && !penable && !hit_sel && !hit_mirror;
    endsequence

    AST_READY_ANSWER: assert property (
        bus_setup_s |=> pready)
        else $error("Setup cycle was not answered in the next cycle.");

    AST_READY_PULSE: assert property (
        pready |=> !pready)
        else $error("Ready stood for more than one cycle.");

    AST_READY_CAUSE: assert property (
        !setup |=> !pready)
        else $error("Ready raised without a setup cycle.");

    AST_UNMAPPED_ERR: assert property (
        bus_unmapped_s |=> pready && pslverr && prdata == '0)
        else $error("Unmapped address not answered with an error.");

    AST_MAPPED_OK: assert property (
        setup && (hit_sel || hit_mirror) |=> !pslverr)
        else $error("Mapped register answered with an error.");

    AST_DATA_QUIET: assert property (
        !pready |-> prdata == '0 && !pslverr)
        else $error("Read data or error shown outside an access cycle.");

    AST_WRITE_NO_DATA: assert property (
        setup && pwrite |=> prdata == '0)
        else $error("Write transfer returned nonzero read data.");

    // The first write makes the select value known; from then on it may
    // only change through another write.
    AST_SEL_KEPT: assert property (
        sel_wr ##1 !sel_wr |=> $stable(gate4_input_select))
        else $error("Select register changed without a write.");
endmodule : logic_cell_gate4_select

//--- testbench/logic_cell_gate4_select_test.sv
// Self-checking testbench for the gate 4 selection and output mirror block.
`timescale 1ns/1ps
module logic_cell_gate4_select_test;
    logic                 pclk;
    logic                 presetn;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [7:0]           paddr;
    logic [31:0]          pwdata;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    gate4_pkg::data_in_t  data_in;
    gate4_pkg::cell_out_t cell_out;
    logic                 gate_four_signal;
    int                   failures;
    int                   cmp_count;
    int                   cycles;
    logic [31:0]          rd;
    logic                 err;
    logic [7:0]           sel;
    logic [1:0]           co;

    logic_cell_gate4_select u_logic_cell_gate4_select (
        .pclk             (pclk),
        .presetn          (presetn),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .paddr            (paddr),
        .pwdata           (pwdata),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .data_in          (data_in),
        .cell_out         (cell_out),
        .gate_four_signal (gate_four_signal)
    );

    always #5 pclk = ~pclk;

    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    // The run is far shorter than this; reaching it means a hang.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            end_sim();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic exp_gate(input logic [7:0] s,
                                      input logic [3:0] d);
        return |(s & {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]});
    endfunction : exp_gate

    task automatic gate_chk(input logic [3:0] d);
        @(posedge pclk);
        data_in <= d;
        repeat (2) @(posedge pclk);
        #1;
        chk("gate", {31'h0, exp_gate(sel, d)}, {31'h0, gate_four_signal});
    endtask : gate_chk

    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {data_in, cell_out, failures, cmp_count, cycles} = '0;
        void'($urandom(2084));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, gate4_pkg::MIRROR_OFF, 32'h0);
        chk("mirror after reset", 32'h0, rd);
        $display("reset test done");
        // Each bit alone, none at all, then random mixes.
        for (int i = 0; i < 24; i++) begin
            sel = (i < 8) ? 8'h01 << i : (i == 8) ? 8'h00 : 8'($urandom);
            apb(1'b1, gate4_pkg::GATE4_SEL_OFF, {24'($urandom), sel});
            apb(1'b0, gate4_pkg::GATE4_SEL_OFF, 32'h0);
            chk("select readback", {24'h0, sel}, rd);
            for (int d = 0; d < 16; d++) gate_chk(4'(d));
        end
        $display("gate test done");
        for (int i = 0; i < 8; i++) begin
            co = 2'($urandom);
            @(posedge pclk);
            cell_out <= co;
            apb(1'b1, gate4_pkg::MIRROR_OFF, 32'hffff_ffff);
            chk("mirror write error", 32'h0, {31'h0, err});
            apb(1'b0, gate4_pkg::MIRROR_OFF, 32'h0);
            chk("mirror", {30'h0, co}, rd);
        end
        $display("mirror test done");
        apb(1'b1, 8'h08, 32'h0000_00ff);
        chk("unmapped write error", 32'h1, {31'h0, err});
        apb(1'b0, 8'h08, 32'h0);
        chk("unmapped read error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        apb(1'b0, gate4_pkg::GATE4_SEL_OFF, 32'h0);
        chk("select kept", {24'h0, sel}, rd);
        $display("unmapped test done");
        sel = 8'ha5;
        apb(1'b1, gate4_pkg::GATE4_SEL_OFF, {24'h0, sel});
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, gate4_pkg::GATE4_SEL_OFF, 32'h0);
        chk("select over reset", {24'h0, sel}, rd);
        gate_chk(4'h6);
        $display("retention test done");
        end_sim();
    end
endmodule : logic_cell_gate4_select_test
